// ==== rtl/tops_core.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// (RULE_01) Enable one closes output path
// (RULE_02) Enable zero shorts load to ground
// (RULE_03) Separate positive and negative limit events trip
// (RULE_04) Current trip select code zero to three
// (RULE_05) Voltage compared, reported only, never limited
// (RULE_06) Overvoltage trip select code zero to three
// (RULE_07) Settings load from saved copies at power-on
// (RULE_08) Monitor mux: ground, current, voltage, status
// (RULE_09) Query returns latest current or voltage
// (RULE_10) Samples stored every 100 ms
// (RULE_11) Die temperature query returns kelvin
// (RULE_12) Mask bit0 current, bit1 voltage
// (RULE_13) One line per sample, comma separated
// (RULE_14) Lowest weight channel rightmost
// (RULE_15) Streaming enable zero off, one on
// (RULE_16) Count zero streams until enable rewritten
// (RULE_17) Nonzero count stops after that many
// (RULE_18) About one line per second
// (RULE_19) Threshold crossing raises overload flag
// (RULE_20) Positive current limit 0..1000, reset 1000; the output is held fixed at 1000 here
// (RULE_21) Trip clears enable until host re-enables
// (RULE_22) Finished counted stream clears enable
module tops_core #(
  parameter int SAMPLE_CYC = tops_pkg::SAMPLE_CYCLES,
  parameter int STREAM_CYC = tops_pkg::STREAM_CYCLES,
  parameter int CNT_W      = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Saved copies of settings
  input  wire logic        nv_output_enable,
  input  wire logic [1:0]  nv_current_trip,
  input  wire logic [1:0]  nv_voltage_trip,
  input  wire logic [1:0]  nv_monitor_sel,
  input  wire logic [1:0]  nv_stream_mask,
  // Analog side
  input  wire logic        ilim_pos_engaged,
  input  wire logic        ilim_neg_engaged,
  input  wire logic signed [15:0] vout_mv,
  input  wire logic signed [15:0] iout_ma,
  input  wire logic signed [15:0] vth_pos_mv,
  input  wire logic signed [15:0] vth_neg_mv,
  input  wire logic [15:0] die_temp_k,
  input  wire logic        status_n,
  output logic             relay_close,
  output logic             relay_short_gnd,
  output logic [1:0]       monitor_connector,
  output logic [11:0]      positive_current_limit,
  // Streamed line output, one item per beat
  output logic             stm_valid,
  input  wire logic        stm_ready,
  output logic             stm_is_value,
  output logic signed [15:0] stm_value,
  output logic [7:0]       stm_char
);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_VAL  = 4'h2,
    ST_SEP  = 4'h4,
    ST_EOL  = 4'h8
  } tops_stm_t;

  typedef struct packed {
    logic              loaded;    // Saved copies taken
    logic              out_en;
    logic [1:0]        trip_i;
    logic [1:0]        trip_v;
    logic [1:0]        mon_sel;
    logic [1:0]        mask;
    logic              stm_en;
    logic [CNT_W-1:0]  stm_cnt;
    logic [CNT_W-1:0]  stm_done;
    logic [3:0]        ovl;
    logic signed [15:0] meas_i;
    logic signed [15:0] meas_v;
    logic [15:0]       die_temperature_query;
    logic [31:0]       smp_tmr;
    logic [31:0]       stm_tmr;
    logic              lane;      // Current stream lane, 1 = voltage
    tops_stm_t         st;
    logic              dph;       // Data phase pending
    logic              dwr;
    logic [7:0]        daddr;
    logic [31:0]       rdata;
    logic              is_value;
    logic signed [15:0] value;
    logic [7:0]        chr;
  } tops_state_t;

  tops_state_t s_q;
  tops_state_t s_d;
  logic        v_pos;    // Voltage above positive threshold
  logic        v_neg;    // Voltage below negative threshold
  logic        trip;     // Any selected trip event
  logic        wr;       // Write data phase this cycle
  logic        rd;       // Read address phase this cycle
  logic        stm_write; // Streaming enable rewritten

  // ----------------------------------------------------------------
  // Protection comparators
  // ----------------------------------------------------------------
  assign v_pos = vout_mv > vth_pos_mv;   // RULE_05
  assign v_neg = vout_mv < vth_neg_mv;   // RULE_05
  assign trip  = (s_q.trip_i[0] & ilim_pos_engaged) | (s_q.trip_i[1] & ilim_neg_engaged) // RULE_03 RULE_04
               | (s_q.trip_v[0] & v_pos) | (s_q.trip_v[1] & v_neg); // RULE_06
  assign wr        = s_q.dph & s_q.dwr;
  assign rd        = hsel & hready & htrans[1] & ~hwrite;
  assign stm_write = wr & (s_q.daddr == tops_pkg::OFF_STM_EN);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Power-on load, taken one clock after reset release
    if (!s_q.loaded) begin
      s_d.loaded  = 1'b1;
      s_d.out_en  = nv_output_enable;   // RULE_07
      s_d.trip_i  = nv_current_trip;
      s_d.trip_v  = nv_voltage_trip;
      s_d.mon_sel = nv_monitor_sel;
      s_d.mask    = (nv_stream_mask == 2'h0) ? tops_pkg::RST_MASK : nv_stream_mask;
    end
    // Bus address phase capture
    s_d.dph = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_d.dph   = 1'b1;
      s_d.dwr   = hwrite;
      s_d.daddr = haddr[7:0];
    end
    // Register writes
    if (wr) begin
      case (s_q.daddr)
        tops_pkg::OFF_OUT_EN:   s_d.out_en  = hwdata[0];
        tops_pkg::OFF_TRIP: begin
          s_d.trip_i = hwdata[tops_pkg::TRIP_I_LSB +: 2];
          s_d.trip_v = hwdata[tops_pkg::TRIP_V_LSB +: 2];
        end
        tops_pkg::OFF_MON_SEL:  s_d.mon_sel = hwdata[1:0];
        tops_pkg::OFF_STM_MASK: begin
          if (hwdata[1:0] != 2'h0) begin
            s_d.mask = hwdata[1:0];     // RULE_12
          end
        end
        tops_pkg::OFF_STM_EN: begin
          s_d.stm_en   = hwdata[0];     // RULE_15
          s_d.stm_done = '0;
          s_d.stm_tmr  = '0;
        end
        tops_pkg::OFF_STM_CNT:  s_d.stm_cnt = hwdata[CNT_W-1:0];
        tops_pkg::OFF_LOAD_NV:  s_d.loaded  = 1'b0;
        default: begin
        end
      endcase
    end
    // Overload flags: set wins over write-one-clear
    if (wr && s_q.daddr == tops_pkg::OFF_OVL) begin
      s_d.ovl = s_q.ovl & ~hwdata[3:0];
    end
    if (v_pos) s_d.ovl[tops_pkg::OVL_VPOS] = 1'b1;            // RULE_19
    if (v_neg) s_d.ovl[tops_pkg::OVL_VNEG] = 1'b1;            // RULE_19
    if (ilim_pos_engaged) s_d.ovl[tops_pkg::OVL_IPOS] = 1'b1; // RULE_03
    if (ilim_neg_engaged) s_d.ovl[tops_pkg::OVL_INEG] = 1'b1; // RULE_03
    // Trip forces output off; beats a same-cycle enable write
    if (trip && s_q.loaded) begin
      s_d.out_en = 1'b0;                // RULE_21
    end
    // Periodic sample store
    if (s_q.smp_tmr >= 32'(SAMPLE_CYC - 1)) begin
      s_d.smp_tmr = '0;
      s_d.meas_i  = iout_ma;            // RULE_10
      s_d.meas_v  = vout_mv;
      s_d.die_temperature_query    = die_temp_k;         // RULE_11
    end else begin
      s_d.smp_tmr = s_q.smp_tmr + 32'h1;
    end
    // Stream pacing timer runs only while enabled
    if (s_q.stm_en && s_q.stm_tmr < 32'(STREAM_CYC - 1) && !stm_write) begin
      s_d.stm_tmr = s_q.stm_tmr + 32'h1;
    end
    // Stream sequencer
    case (s_q.st)
      ST_IDLE: begin
        if (s_q.stm_en && s_q.stm_tmr >= 32'(STREAM_CYC - 1) && !stm_write) begin // RULE_18
          s_d.stm_tmr  = '0;
          s_d.lane     = s_q.mask[1];   // RULE_14
          s_d.is_value = 1'b1;
          s_d.value    = s_q.mask[1] ? s_q.meas_v : s_q.meas_i;
          s_d.st       = ST_VAL;
        end
      end
      ST_VAL: begin
        if (stm_ready) begin
          if (s_q.lane && s_q.mask[0]) begin
            s_d.is_value = 1'b0;
            s_d.chr      = tops_pkg::ASCII_COMMA; // RULE_13
            s_d.st       = ST_SEP;
          end else begin
            s_d.is_value = 1'b0;
            s_d.chr      = tops_pkg::ASCII_LF;
            s_d.st       = ST_EOL;
          end
        end
      end
      ST_SEP: begin
        if (stm_ready) begin
          s_d.lane     = 1'b0;
          s_d.is_value = 1'b1;
          s_d.value    = s_q.meas_i;    // RULE_14
          s_d.st       = ST_VAL;
        end
      end
      ST_EOL: begin
        if (stm_ready) begin
          s_d.st = ST_IDLE;
          if (s_q.stm_cnt != '0) begin
            s_d.stm_done = s_q.stm_done + CNT_W'(1);
            if (s_q.stm_done + CNT_W'(1) >= s_q.stm_cnt) begin
              s_d.stm_en = 1'b0;        // RULE_17 RULE_22
            end
          end                           // RULE_16
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Read data for the coming data phase
    s_d.rdata = '0;
    if (rd) begin
      case (haddr[7:0])
        tops_pkg::OFF_OUT_EN:   s_d.rdata = {31'h0, s_d.out_en};
        tops_pkg::OFF_TRIP:     s_d.rdata = {26'h0, s_d.trip_v, 2'h0, s_d.trip_i};
        tops_pkg::OFF_MON_SEL:  s_d.rdata = {30'h0, s_d.mon_sel};
        tops_pkg::OFF_STM_MASK: s_d.rdata = {30'h0, s_d.mask};
        tops_pkg::OFF_STM_EN:   s_d.rdata = {31'h0, s_d.stm_en};
        tops_pkg::OFF_STM_CNT:  s_d.rdata = 32'(s_d.stm_cnt);
        tops_pkg::OFF_MEAS_I:   s_d.rdata = 32'(signed'(s_q.meas_i)); // RULE_09
        tops_pkg::OFF_MEAS_V:   s_d.rdata = 32'(signed'(s_q.meas_v)); // RULE_09
        tops_pkg::OFF_DIE_TEMPERATURE_QUERY:     s_d.rdata = {16'h0, s_q.die_temperature_query};        // RULE_11
        tops_pkg::OFF_OVL:      s_d.rdata = {28'h0, s_q.ovl};         // RULE_19
        default:                s_d.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q          <= '0;
      s_q.trip_v   <= tops_pkg::RST_TRIP_V;
      s_q.trip_i   <= tops_pkg::RST_TRIP_I;
      s_q.mon_sel  <= tops_pkg::RST_MON;  // RULE_08
      s_q.mask     <= tops_pkg::RST_MASK;
      s_q.st       <= ST_IDLE;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Relay held safe until saved settings are loaded
  assign relay_close     = s_q.out_en & s_q.loaded;     // RULE_01
  assign relay_short_gnd = ~relay_close;                // RULE_02
  assign monitor_connector = s_q.mon_sel;               // RULE_08
  // Limit value storage lives elsewhere; reset value presented here
  assign positive_current_limit = tops_pkg::ILIM_POS_RST; // RULE_20
  assign hrdata    = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign stm_valid    = (s_q.st != ST_IDLE);
  assign stm_is_value = s_q.is_value;
  assign stm_value    = s_q.value;
  assign stm_char     = s_q.chr;

  // Status line is routed by the analog mux; not used by this logic
  logic unused_ok;
  assign unused_ok = status_n ^ hsize[0];

endmodule : tops_core

// ==== rtl/tops_pkg.sv ====
package tops_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_OUT_EN   = 8'h00; // Output enable setting
  localparam logic [7:0] OFF_TRIP     = 8'h04; // Current and overvoltage trip selects
  localparam logic [7:0] OFF_MON_SEL  = 8'h08; // Monitor source select
  localparam logic [7:0] OFF_STM_MASK = 8'h0C; // Stream channel mask
  localparam logic [7:0] OFF_STM_EN   = 8'h10; // Streaming enable setting
  localparam logic [7:0] OFF_STM_CNT  = 8'h14; // Stream count
  localparam logic [7:0] OFF_MEAS_I   = 8'h18; // Latest current sample, mA
  localparam logic [7:0] OFF_MEAS_V   = 8'h1C; // Latest voltage sample, mV
  localparam logic [7:0] OFF_DIE_TEMPERATURE_QUERY     = 8'h20; // Latest die temperature, K
  localparam logic [7:0] OFF_OVL      = 8'h24; // Overload flags, write one to clear
  localparam logic [7:0] OFF_LOAD_NV  = 8'h28; // Write reloads saved copies

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TRIP_I_LSB = 0; // Current limit trip select, 2 bits
  localparam int TRIP_V_LSB = 4; // Overvoltage trip select, 2 bits
  localparam int OVL_VPOS   = 0; // Positive overvoltage flag
  localparam int OVL_VNEG   = 1; // Negative overvoltage flag
  localparam int OVL_IPOS   = 2; // Positive current limit flag
  localparam int OVL_INEG   = 3; // Negative current limit flag

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [1:0] MON_GND    = 2'h0;
  localparam logic [1:0] MON_CURRENT_MONITOR   = 2'h1;
  localparam logic [1:0] MON_VOLTAGE_MONITOR   = 2'h2;
  localparam logic [1:0] MON_STATUS = 2'h3;
  localparam logic [1:0] RST_MON    = 2'h0;
  localparam logic [1:0] RST_TRIP_V = 2'h3;
  localparam logic [1:0] RST_TRIP_I = 2'h0;
  localparam logic [1:0] RST_MASK   = 2'h3;
  localparam logic [11:0] ILIM_POS_RST = 12'h3E8; // 1000 mA
  localparam logic [7:0] ASCII_COMMA = 8'h2C;
  localparam logic [7:0] ASCII_LF    = 8'h0A;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ        = 25000000;
  localparam longint SAMPLE_MS     = 100;
  localparam longint STREAM_MS     = 1000;
  localparam int     SAMPLE_CYCLES = int'(CLK_HZ * SAMPLE_MS / 1000);
  localparam int     STREAM_CYCLES = int'(CLK_HZ * STREAM_MS / 1000);

endpackage : tops_pkg

// ==== verif/tops_core_sva.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Port checker for the protection and stream core
// ----------------------------------------------------------------
module tops_chk (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   ce,
  input wire logic                   hsel,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic                   hready,
  input wire logic                   relay_close,
  input wire logic                   relay_short_gnd,
  input wire logic [1:0]             monitor_connector,
  input wire logic [11:0]            positive_current_limit,
  input wire logic                   stm_valid,
  input wire logic                   stm_ready,
  input wire logic                   stm_is_value,
  input wire logic signed [15:0]     stm_value,
  input wire logic [7:0]             stm_char
);
  // Write address phase taken; settings may move two edges later
  logic wr_ph;
  assign wr_ph = hsel && hready && htrans[1] && hwrite;
  // Item handed over this edge
  logic take;
  assign take = ce && stm_valid && stm_ready;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_short_inverse: assert property (relay_short_gnd == !relay_close)
    else $error("ground short not opposite to output path");
  a_limit_fixed: assert property (positive_current_limit == 12'h3E8)
    else $error("positive current limit not at its fixed value");
  a_mon_reset: assert property ($fell(rst) |-> monitor_connector == 2'h0)
    else $error("monitor source not ground after reset");
  a_mon_held: assert property (!$fell(rst) && !$past(wr_ph) && !$past(wr_ph, 2) |=> $stable(monitor_connector))
    else $error("monitor source moved without a write");
  a_off_holds: assert property (!$fell(rst) && !$past(wr_ph) && !$past(wr_ph, 2) && !relay_close |=> !relay_close)
    else $error("output path closed without a host write");
  a_item_hold: assert property (stm_valid && !stm_ready |=> stm_valid && $stable(stm_is_value) &&
    (stm_is_value ? $stable(stm_value) : $stable(stm_char))) else $error("stream item dropped or changed");
  a_comma_value: assert property (take && !stm_is_value && stm_char == 8'h2C |=> stm_valid && stm_is_value)
    else $error("comma not followed by a value");
  a_lf_idle: assert property (take && !stm_is_value && stm_char == 8'h0A |=> !stm_valid)
    else $error("line end not followed by idle");
  a_char_legal: assert property (stm_valid && !stm_is_value |-> stm_char == 8'h2C || stm_char == 8'h0A)
    else $error("stream character neither comma nor line end");
endmodule : tops_chk

bind tops_core tops_chk u_chk (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .relay_close(relay_close), .relay_short_gnd(relay_short_gnd),
  .monitor_connector(monitor_connector), .positive_current_limit(positive_current_limit),
  .stm_valid(stm_valid), .stm_ready(stm_ready), .stm_is_value(stm_is_value), .stm_value(stm_value),
  .stm_char(stm_char));

// ==== verif/tops_sink.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Host-side line receiver; slow mode stalls every other cycle
// ----------------------------------------------------------------
module tops_sink (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               slow,
  input wire logic               stm_valid,
  input wire logic               stm_is_value,
  input wire logic signed [15:0] stm_value,
  input wire logic [7:0]         stm_char,
  output logic                   stm_ready
);
  logic [16:0] q[$];    // Received items, value flag on top
  int          lf_t[$]; // Cycle of each line end
  int          cyc = 0; // Free cycle count
  // Take items only when both sides agree at an edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    stm_ready <= rst ? 1'b0 : (slow ? !stm_ready : 1'b1);
    if (!rst && stm_valid && stm_ready) begin
      q.push_back(stm_is_value ? {1'b1, stm_value} : {9'h000, stm_char});
      if (!stm_is_value && stm_char == 8'h0A) lf_t.push_back(cyc);
    end
  end
endmodule : tops_sink

// ==== verif/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tops_row_t;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0, ilp = 1'b0, iln = 1'b0, slow = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0, nv_ti = 2'h1, nv_tv = 2'h2, nv_mon = 2'h2, nv_mask = 2'h1, monitor_connector;
  logic        nv_oe = 1'b0, hready, hreadyout, hresp, relay_close, relay_short_gnd;
  logic        stm_valid, stm_ready, stm_is_value;
  logic signed [15:0] vout = 16'h0000, stm_value;
  logic signed [15:0] iout = 16'hFFE9, positive_voltage_threshold = 16'h07D0, negative_voltage_threshold = 16'hF830; // Analog levels driven by the bench
  logic [11:0] pcl;
  logic [7:0]  stm_char;
  int          failures = 0, checks = 0;
  // Ordinary settings: written, read back; monitor select and output enable also seen at the pins
  tops_row_t rows [11] = '{'{tops_pkg::OFF_MON_SEL, 32'h0, 32'h0}, '{tops_pkg::OFF_MON_SEL, 32'h1, 32'h1},
    '{tops_pkg::OFF_MON_SEL, 32'h2, 32'h2}, '{tops_pkg::OFF_MON_SEL, 32'h3, 32'h3},
    '{tops_pkg::OFF_STM_MASK, 32'h2, 32'h2}, '{tops_pkg::OFF_STM_MASK, 32'h0, 32'h2},
    '{tops_pkg::OFF_STM_MASK, 32'h3, 32'h3}, '{tops_pkg::OFF_STM_CNT, 32'h5, 32'h5},
    '{tops_pkg::OFF_OUT_EN, 32'h1, 32'h1}, '{tops_pkg::OFF_OUT_EN, 32'h0, 32'h0}, '{8'h3C, 32'h7, 32'h0}};
  assign hready = hreadyout;
  always #20 clk = ~clk;
  // Short pacing counts so streams fit the run
  tops_core #(.SAMPLE_CYC(10), .STREAM_CYC(20)) u_dut (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nv_output_enable(nv_oe), .nv_current_trip(nv_ti),
    .nv_voltage_trip(nv_tv), .nv_monitor_sel(nv_mon), .nv_stream_mask(nv_mask), .ilim_pos_engaged(ilp),
    .ilim_neg_engaged(iln), .vout_mv(vout), .iout_ma(iout), .vth_pos_mv(positive_voltage_threshold), .vth_neg_mv(negative_voltage_threshold),
    .die_temp_k(16'h012C), .status_n(1'b1), .relay_close(relay_close), .relay_short_gnd(relay_short_gnd),
    .monitor_connector(monitor_connector), .positive_current_limit(pcl), .stm_valid(stm_valid),
    .stm_ready(stm_ready), .stm_is_value(stm_is_value), .stm_value(stm_value), .stm_char(stm_char));
  tops_sink u_sink (.clk(clk), .rst(rst), .slow(slow), .stm_valid(stm_valid), .stm_is_value(stm_is_value),
    .stm_value(stm_value), .stm_char(stm_char), .stm_ready(stm_ready));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait for ready; a hang ends the run
  task automatic wait_rdy;
    int n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      if (++n > 50) begin failures++; $display("[ERR] %0t bus hang", $time); results(); end
      @(posedge clk);
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h000000, a}; hwrite <= w;
    wait_rdy();
    htrans <= 2'h0; hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0); chk(rd, e);
  endtask : rchk
  // One stream run; count zero is stopped by the host after three lines
  task automatic stream(input logic [1:0] m, input int n, input logic s);
    logic [16:0] e[$];
    int k = 0, nl = (n == 0) ? 3 : n, c;
    u_sink.q.delete(); u_sink.lf_t.delete(); slow <= s;
    bus(1'b1, tops_pkg::OFF_STM_MASK, {30'h0, m}); bus(1'b1, tops_pkg::OFF_STM_CNT, n); bus(1'b1, tops_pkg::OFF_STM_EN, 32'h1);
    while (u_sink.lf_t.size() < nl) begin
      if (++k > 2000) begin failures++; $display("[ERR] %0t stream hang", $time); results(); end
      @(posedge clk);
    end
    if (n == 0) bus(1'b1, tops_pkg::OFF_STM_EN, 32'h0);
    repeat (10) @(posedge clk);
    c = u_sink.lf_t.size();
    repeat (60) @(posedge clk);
    chk(u_sink.lf_t.size(), (n == 0) ? c : n);
    if (n != 0) rchk(tops_pkg::OFF_STM_EN, 32'h0);
    for (int j = 0; j < nl; j++) begin
      if (m[1]) e.push_back({1'b1, 16'h04D2});
      if (m == 2'h3) e.push_back({9'h000, 8'h2C});
      if (m[0]) e.push_back({1'b1, 16'hFFE9});
      e.push_back({9'h000, 8'h0A});
      if (j > 0) chk(u_sink.lf_t[j] - u_sink.lf_t[j-1] inside {[10:40]}, 1'b1);
    end
    for (int j = 0; j < e.size(); j++) chk(u_sink.q[j], e[j]);
  endtask : stream
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk(monitor_connector, 2'h2);
    chk({relay_close, relay_short_gnd, pcl}, {2'b01, 12'h3E8});
    rchk(tops_pkg::OFF_TRIP, 32'h21);
    rchk(tops_pkg::OFF_STM_MASK, 32'h1);
    nv_oe <= 1'b1; nv_ti <= 2'h0; nv_tv <= 2'h0; nv_mon <= 2'h3; nv_mask <= 2'h3;
    bus(1'b1, tops_pkg::OFF_LOAD_NV, 32'h1);
    repeat (2) @(posedge clk);
    chk({relay_close, monitor_connector}, 3'h7);
    rchk(tops_pkg::OFF_TRIP, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d); rchk(rows[i].a, rows[i].e);
      repeat (2) @(posedge clk);
      if (rows[i].a == tops_pkg::OFF_MON_SEL) chk(monitor_connector, rows[i].d);
      if (rows[i].a == tops_pkg::OFF_OUT_EN) chk({relay_close, relay_short_gnd}, {rows[i].d[0], !rows[i].d[0]});
    end
    // Every trip code against each event, current then voltage
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, tops_pkg::OFF_TRIP, i[3] ? {26'h0, i[1:0], 4'h0} : {30'h0, i[1:0]});
      bus(1'b1, tops_pkg::OFF_OUT_EN, 32'h1);
      if (i[3]) vout <= i[2] ? 16'hF448 : 16'h0BB8;
      else if (i[2]) iln <= 1'b1;
      else ilp <= 1'b1;
      repeat (3) @(posedge clk);
      ilp <= 1'b0; iln <= 1'b0; vout <= 16'h0000;
      repeat (3) @(posedge clk);
      chk(relay_close, !i[i[2]]);
      rchk(tops_pkg::OFF_OUT_EN, {31'h0, !i[i[2]]});
      rchk(tops_pkg::OFF_OVL, 32'h1 << {!i[3], i[2]});
      bus(1'b1, tops_pkg::OFF_OVL, 32'hF);
    end
    vout <= 16'h04D2;
    repeat (25) @(posedge clk);
    bus(1'b0, tops_pkg::OFF_MEAS_I, 32'h0); chk(rd[15:0], 16'hFFE9);
    bus(1'b0, tops_pkg::OFF_MEAS_V, 32'h0); chk(rd[15:0], 16'h04D2);
    rchk(tops_pkg::OFF_DIE_TEMPERATURE_QUERY, 32'h12C);
    stream(2'h3, 2, 1'b1);
    stream(2'h1, 1, 1'b0);
    stream(2'h2, 0, 1'b1);
    results();
  end
endmodule : testbench
